// file: hw/cog_clock_out.sv
// Clock output enable, synchronous gating, polarity and skew for the driver banks.
// Assumes bank clocks come from logic on clk_sys; control pins are asynchronous.
//
// Overview of operation
// RULE_01 - Global tristate pin high puts every driver in high-impedance, overriding all.
// RULE_02 - Otherwise each output follows stored mode: always on, off, or secondary pin.
// RULE_03 - Secondary-enabled output drives while its pin is 0, high-impedance at 1.
// RULE_04 - Gate pin never tristates; it only holds a gated output at a level.
// RULE_05 - Gate 0 holds true output low, inverted high; gate 1 passes clock.
// RULE_06 - Gated start and stop align to the selected bank clock; no runt pulses.
// RULE_07 - Gate control chosen per bank; other banks ignore the gate pin.
// RULE_08 - Polarity per output when single-ended, one polarity per pair when differential.
// RULE_09 - Each bank is one differential or two single-ended outputs, one standard.
// RULE_10 - Small variant has five banks, large variant ten, each fully configurable.
// RULE_11 - Single-ended slew has four settings; differential runs one fixed slew. Code: only output A's slew reaches slew_sel.
// RULE_12 - Each output takes its own programmed fixed delay from its skew unit.
// RULE_13 - Gate pin synchronised, applied only while bank clock sits at inactive level.
// RULE_14 - Tristate and secondary pins act on enables without the gate's clock alignment.
`timescale 1ns/1ns
`default_nettype none
`include "cog_consts.svh"

module cog_clock_out #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Control pins, asynchronous
  input  wire logic        global_tristate_pin,
  input  wire logic        secondary_enable_x,
  input  wire logic        secondary_enable_y,
  input  wire logic        sync_gate_pin,
  // Internal bank clocks, one per bank
  input  wire logic [9:0]  bank_clk,
  // Configuration port
  input  wire logic [4:0]  cfg_addr,
  input  wire logic [31:0] cfg_wdata,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  output logic      [31:0] cfg_rdata,
  // Driver bank outputs
  output logic      [9:0]  out_a,
  output logic      [9:0]  out_a_oe,
  output logic      [9:0]  out_b,
  output logic      [9:0]  out_b_oe,
  output logic      [9:0]  bank_diff,
  output logic      [19:0] slew_sel
);

  localparam int NB = `COG_BANKS_LARGE;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Driver enable from the stored mode and the synchronised pins
  function automatic logic oe_of(input logic [1:0] mode, input logic gtri,
                                 input logic sx, input logic sy);
    logic en;
    en = 1'b0;
    case (cog_pkg::cog_oe_mode_t'(mode))
      cog_pkg::COG_OE_ALWAYS: en = 1'b1;
      cog_pkg::COG_OE_OFF:    en = 1'b0;
      cog_pkg::COG_OE_SEC_X:  en = ~sx;
      cog_pkg::COG_OE_SEC_Y:  en = ~sy;
      default:                en = 1'b0;
    endcase
    return en & ~gtri;
  endfunction

  // Pick one tap of a delay history
  function automatic logic tap_of(input logic [15:0] hist, input logic [3:0] sel);
    return hist[sel];
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] pin_meta_ff;
  logic [3:0] pin_sync_ff;
  logic [3:0] nxt_pin_meta;
  logic [3:0] nxt_pin_sync;

  // Two stages; only the second stage is read by logic
  always_comb begin
    nxt_pin_meta = {sync_gate_pin, secondary_enable_y, secondary_enable_x,
                    global_tristate_pin};
    nxt_pin_sync = pin_meta_ff;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_meta_ff <= 4'h1;
      pin_sync_ff <= 4'h1;
    end else begin
      pin_meta_ff <= nxt_pin_meta;
      pin_sync_ff <= nxt_pin_sync;
    end
  end

  logic gtri_s;
  logic sec_x_s;
  logic sec_y_s;
  logic gate_s;
  assign gtri_s  = pin_sync_ff[0];
  assign sec_x_s = pin_sync_ff[1];
  assign sec_y_s = pin_sync_ff[2];
  assign gate_s  = pin_sync_ff[3];

  // ----------------------------------------
  // Configuration store and read port
  // ----------------------------------------
  logic [`COG_CFG_W-1:0] cfg_ff     [NB];
  logic [`COG_CFG_W-1:0] nxt_cfg    [NB];
  logic [31:0]           rdata_ff;
  logic [31:0]           nxt_rdata;
  logic [9:0]            gate_on_ff;

  // Writes land in the addressed bank word; status is read-only
  always_comb begin
    for (int b = 0; b < NB; b++) begin
      nxt_cfg[b] = cfg_ff[b];
      if (cfg_wr && cfg_addr == (`COG_IDX_BANK0 + 5'(b))) begin
        nxt_cfg[b] = cfg_wdata[`COG_CFG_W-1:0];
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_comb begin
    nxt_rdata = 32'h00000000;
    if (cfg_rd) begin
      if (cfg_addr == `COG_IDX_STATUS) begin
        nxt_rdata[`COG_S_GTRI]  = gtri_s;
        nxt_rdata[`COG_S_SEC_X] = sec_x_s;
        nxt_rdata[`COG_S_SEC_Y] = sec_y_s;
        nxt_rdata[`COG_S_GATE]  = gate_s;
        nxt_rdata[`COG_S_GATE_ON +: 10] = gate_on_ff;
      end else begin
        for (int b = 0; b < NB; b++) begin
          if (cfg_addr == (`COG_IDX_BANK0 + 5'(b))) begin
            nxt_rdata = {{(32-`COG_CFG_W){1'b0}}, cfg_ff[b]};
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int b = 0; b < NB; b++) begin
        cfg_ff[b] <= `COG_CFG_RESET;
      end
      rdata_ff <= 32'h00000000;
    end else begin
      for (int b = 0; b < NB; b++) begin
        cfg_ff[b] <= nxt_cfg[b];
      end
      rdata_ff <= nxt_rdata;
    end
  end

  assign cfg_rdata = rdata_ff;

  // ----------------------------------------
  // Per-bank gating, skew and drivers
  // ----------------------------------------
  genvar gb;
  generate
    for (gb = 0; gb < NB; gb++) begin : g_bank
      logic [`COG_CFG_W-1:0] cfg;
      logic        present;
      logic        diff;
      logic        gate_on_nxt;
      logic [15:0] hist_ff;
      logic [15:0] nxt_hist;
      logic        src;
      logic        nxt_a;
      logic        nxt_b;
      logic        nxt_a_oe;
      logic        nxt_b_oe;
      logic [1:0]  nxt_slew_a;
      logic        o_a_ff;
      logic        o_b_ff;
      logic        oe_a_ff;
      logic        oe_b_ff;
      logic        diff_ff;
      logic [1:0]  slew_a_ff;

      assign cfg = cfg_ff[gb];
      // RULE_10 bank count
      assign present = LARGE_VARIANT || (gb < `COG_BANKS_SMALL);
      // RULE_09 bank pairing
      assign diff = cfg[`COG_F_DIFF];

      // Gate changes only while the bank clock is low, so every pulse is whole
      always_comb begin
        gate_on_nxt = gate_on_ff[gb];
        // RULE_13 inactive-level update
        // RULE_06 clock-aligned gating
        if (!bank_clk[gb]) begin
          gate_on_nxt = gate_s;
        end
        // RULE_07 per-bank select
        // RULE_04 level hold only
        src = bank_clk[gb] & (gate_on_ff[gb] | ~cfg[`COG_F_GATE_SEL]);
        nxt_hist = {hist_ff[14:0], src};
      end

      // Drivers: delay tap, polarity, enable, slew
      always_comb begin
        // RULE_12 per-output delay
        // RULE_05 gated level by polarity
        // RULE_08 polarity per output or pair
        nxt_a = tap_of(hist_ff, cfg[`COG_F_SKEW_A]) ^ cfg[`COG_F_POL_A];
        nxt_b = diff ? ~nxt_a
                     : tap_of(hist_ff, cfg[`COG_F_SKEW_B]) ^ cfg[`COG_F_POL_B];
        // RULE_01 global override
        // RULE_02 stored enable mode
        // RULE_03 secondary pin low enables
        // RULE_14 no gate alignment on enables
        nxt_a_oe = present & oe_of(cfg[`COG_F_MODE_A], gtri_s, sec_x_s, sec_y_s);
        nxt_b_oe = diff ? nxt_a_oe
                        : present & oe_of(cfg[`COG_F_MODE_B], gtri_s, sec_x_s, sec_y_s);
        // RULE_11 slew choice
        // Only output A slew leaves the block; the port has two bits per bank
        nxt_slew_a = diff ? `COG_SLEW_FIXED : cfg[`COG_F_SLEW_A];
      end

      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          gate_on_ff[gb] <= 1'b0;
          hist_ff   <= 16'h0000;
          o_a_ff    <= 1'b0;
          o_b_ff    <= 1'b0;
          oe_a_ff   <= 1'b0;
          oe_b_ff   <= 1'b0;
          diff_ff   <= 1'b0;
          slew_a_ff <= 2'h0;
        end else begin
          gate_on_ff[gb] <= gate_on_nxt;
          hist_ff   <= nxt_hist;
          o_a_ff    <= nxt_a;
          o_b_ff    <= nxt_b;
          oe_a_ff   <= nxt_a_oe;
          oe_b_ff   <= nxt_b_oe;
          diff_ff   <= diff;
          slew_a_ff <= nxt_slew_a;
        end
      end

      assign out_a[gb]           = o_a_ff;
      assign out_b[gb]           = o_b_ff;
      assign out_a_oe[gb]        = oe_a_ff;
      assign out_b_oe[gb]        = oe_b_ff;
      assign bank_diff[gb]       = diff_ff;
      assign slew_sel[2*gb +: 2] = slew_a_ff;
    end
  endgenerate

endmodule

`default_nettype wire

// file: hw/cog_consts.svh
// Constants for the clock output enable and gating block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef COG_CONSTS_SVH
`define COG_CONSTS_SVH

// ----------------------------------------
// Bank counts
// ----------------------------------------
`define COG_BANKS_LARGE 10
`define COG_BANKS_SMALL 5

// ----------------------------------------
// Register indexes (byte address = 4 x index)
// ----------------------------------------
`define COG_IDX_BANK0   5'h00
`define COG_IDX_STATUS  5'h10

// ----------------------------------------
// Bank configuration word fields
// ----------------------------------------
`define COG_F_MODE_A    1:0
`define COG_F_MODE_B    3:2
`define COG_F_POL_A     4
`define COG_F_POL_B     5
`define COG_F_GATE_SEL  6
`define COG_F_DIFF      7
`define COG_F_SLEW_A    9:8
`define COG_F_SLEW_B    11:10
`define COG_F_SKEW_A    15:12
`define COG_F_SKEW_B    19:16
`define COG_CFG_W       20
`define COG_CFG_RESET   20'h00000

// ----------------------------------------
// Status word fields
// ----------------------------------------
`define COG_S_GTRI      0
`define COG_S_SEC_X     1
`define COG_S_SEC_Y     2
`define COG_S_GATE      3
`define COG_S_GATE_ON   16

// ----------------------------------------
// Delay line and fixed slew
// ----------------------------------------
`define COG_SKEW_TAPS   16
`define COG_SLEW_FIXED  2'h0

`endif

// file: hw/cog_pkg.sv
// Types for the clock output enable and gating block.
// Assumes the constants header sits beside it.
`include "cog_consts.svh"

package cog_pkg;

  // Per-output enable source held in the bank configuration
  typedef enum logic [1:0] {
    COG_OE_ALWAYS = 2'h0,
    COG_OE_OFF    = 2'h1,
    COG_OE_SEC_X  = 2'h2,
    COG_OE_SEC_Y  = 2'h3
  } cog_oe_mode_t;

endpackage

// file: sim/cog_board.sv
// Board-side model: drives the control pins and the bank clocks.
// Assumes the bench sets the pin requests just after a clock edge.
`timescale 1ns/1ns
`default_nettype none
module cog_board (
  // Clock and pin requests {gate, y, x, tristate}
  input  wire logic       clk_sys,
  input  wire logic [3:0] want,
  // Pins and bank clocks
  output logic            global_tristate_pin,
  output logic            secondary_enable_x,
  output logic            secondary_enable_y,
  output logic            sync_gate_pin,
  output logic [9:0]      bank_clk
);
  logic [2:0] cnt = 3'h0;
  // Pins land one edge late, unaligned to the bank clocks
  always @(posedge clk_sys) begin
    {sync_gate_pin, secondary_enable_y, secondary_enable_x, global_tristate_pin} <= want;
    cnt <= cnt + 3'h1;
  end
  // One shared slow clock, so banks can be compared cycle by cycle
  assign bank_clk = {10{cnt[2]}};
endmodule
`default_nettype wire

// file: sim/cog_chk.sv
// Port checker for the clock output block.
// Assumes one clock domain with synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module cog_chk (
  // Clock, reset, pins and strobes
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        global_tristate_pin,
  input wire logic        secondary_enable_x,
  input wire logic        secondary_enable_y,
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic [4:0]  cfg_addr,
  // Design outputs
  input wire logic [31:0] cfg_rdata,
  input wire logic [9:0]  out_a,
  input wire logic [9:0]  out_a_oe,
  input wire logic [9:0]  out_b,
  input wire logic [9:0]  out_b_oe,
  input wire logic [9:0]  bank_diff,
  input wire logic [19:0] slew_sel
);
  logic [19:0] dmask;
  // Slew pairs that belong to differential banks
  always_comb begin
    for (int i = 0; i < 10; i++) dmask[2*i +: 2] = {2{bank_diff[i]}};
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  chk_tri_off: assert property (global_tristate_pin[*5] |-> (out_a_oe | out_b_oe) == 10'h000)
    else $error("driver enabled under tristate");
  chk_tri_lag: assert property ((out_a_oe | out_b_oe) != 10'h000 |-> !$past(global_tristate_pin, 3))
    else $error("enable despite tristate three cycles back");
  chk_oe_steady: assert property (($stable(global_tristate_pin) && $stable(secondary_enable_x)
    && $stable(secondary_enable_y) && !cfg_wr)[*6] |-> $stable(out_a_oe) && $stable(out_b_oe))
    else $error("enable moved without a cause");
  chk_diff_pair: assert property ($stable(bank_diff)[*3] |-> ((out_a ^ out_b) | ~bank_diff) == 10'h3FF)
    else $error("differential pair not complementary");
  chk_diff_slew: assert property ($stable(bank_diff)[*2] |-> (slew_sel & dmask) == 20'h00000)
    else $error("slew selected on differential bank");
  chk_rdata_idle: assert property (!$past(cfg_rd) |-> cfg_rdata == 32'h00000000)
    else $error("read data outside its cycle");
  chk_unmapped_rd: assert property (cfg_rd && cfg_addr > 5'h09 && cfg_addr != 5'h10 |=> cfg_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_upper_zero: assert property (cfg_rd && cfg_addr < 5'h0A |=> cfg_rdata[31:20] == 12'h000)
    else $error("bank word upper bits set");
endmodule
bind cog_clock_out cog_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .global_tristate_pin(global_tristate_pin), .secondary_enable_x(secondary_enable_x),
  .secondary_enable_y(secondary_enable_y), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
  .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata), .out_a(out_a), .out_a_oe(out_a_oe),
  .out_b(out_b), .out_b_oe(out_b_oe), .bank_diff(bank_diff), .slew_sel(slew_sel));
`default_nettype wire

// file: sim/tb_clock_output_enable_gating.sv
// Bench for the clock output block: config port tasks and pin sequences.
// Assumes the board model drives pins and bank clocks.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_clock_output_enable_gating;
  logic        clk_sys, rst_n, cfg_wr, cfg_rd, ex, mon;
  logic        gtp, sx, sy, sg;
  logic [4:0]  cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [3:0]  want;
  logic [9:0]  bclk, out_a, out_a_oe, out_b, out_b_oe, bank_diff;
  logic [19:0] slew_sel;
  logic [15:0] h;
  logic [1:0]  seen;
  int          fails = 0, n_checks = 0, run = 0, cyc = 0;
  cog_board BRD (.clk_sys(clk_sys), .want(want), .global_tristate_pin(gtp),
    .secondary_enable_x(sx), .secondary_enable_y(sy), .sync_gate_pin(sg), .bank_clk(bclk));
  cog_clock_out #(.LARGE_VARIANT(1'b1)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
    .global_tristate_pin(gtp), .secondary_enable_x(sx), .secondary_enable_y(sy),
    .sync_gate_pin(sg), .bank_clk(bclk), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .out_a(out_a),
    .out_a_oe(out_a_oe), .out_b(out_b), .out_b_oe(out_b_oe), .bank_diff(bank_diff),
    .slew_sel(slew_sel));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Each call opens on a fresh rising edge, so a strobe never drops and rises in one step
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    step(1);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    step(1);
    cfg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    step(1);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    step(1);
    cfg_rd <= 1'b0;
    #1 `CHK(cfg_rdata, e)
  endtask
  task automatic final_report;
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Pulse widths on a gated output; a runt shows as a short high run
  always @(negedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      final_report;
    end
    if (!mon) run = 0;
    else if (out_a[1] === 1'b1) run++;
    else begin
      if (run != 0) `CHK(run, 4)
      run = 0;
    end
  end
  initial begin
    {rst_n, cfg_wr, cfg_rd, mon, cfg_addr, cfg_wdata} = '0;
    want = 4'h8;
    step(3);
    rst_n <= 1'b1;
    step(1);
    for (int b = 0; b < 10; b++) rd(b[4:0], 32'h0);
    wr(5'h03, 32'hFFFFFFFF);
    rd(5'h03, 32'h000FFFFF);
    rd(5'h0C, 32'h0);
    wr(5'h03, 32'h0);
    // Every stored enable mode against every tristate and secondary pin combination
    for (int m = 0; m < 4; m++) begin
      wr(5'h00, 32'(m * 5));
      for (int p = 0; p < 8; p++) begin
        want[2:0] <= p[2:0];
        step(8);
        ex = !p[0] && (m == 0 || (m == 2 && !p[1]) || (m == 3 && !p[2]));
        #1 `CHK({out_b_oe[0], out_a_oe[0]}, {2{ex}})
      end
    end
    want <= 4'h0;
    wr(5'h01, 32'h40);
    wr(5'h02, 32'h50);
    wr(5'h04, 32'h10);
    step(40);
    seen = 2'h0;
    repeat (8) begin
      step(1);
      #1 `CHK({out_a_oe[1], out_a[1], out_a[2], out_b[2]}, 4'hA)
      seen[out_a[4]] = 1'b1;
    end
    `CHK(seen, 2'h3)
    mon = 1'b1;
    want[3] <= 1'b1;
    step(20);
    rd(5'h10, 32'h03FF0008);
    repeat (8) begin
      step(1);
      #1 `CHK({out_a[2], out_b[2]}, {~out_a[1], out_a[1]})
    end
    // Gate flips at awkward offsets against the bank clock
    for (int k = 1; k < 8; k++) begin
      step(k + 3);
      want[3] <= ~want[3];
    end
    step(30);
    mon = 1'b0;
    wr(5'h05, 32'h390);
    wr(5'h06, 32'h200);
    wr(5'h07, 32'h0);
    wr(5'h08, 32'h4000);
    step(30);
    #1 `CHK({bank_diff[5], slew_sel[11:10], slew_sel[13:12]}, 5'h12)
    for (int i = 0; i < 16; i++) begin
      step(1);
      #1 h = {h[14:0], out_a[7]};
      if (i > 7) `CHK(out_a[8], h[4])
      if (i > 7) `CHK({out_a[5], out_b[5]}, {~out_a[7], out_a[7]})
    end
    final_report;
  end
endmodule
`default_nettype wire
